// ===== src/adc_host_bus_glue.sv
// Host-side glue: start, completion, read strobe and 8+4 split read
`timescale 1ns/1ps
module adc_host_bus_glue (
  input wire logic clk,
  input wire logic rstn,
  // Host command side
  input wire logic reqValid,
  input wire logic [1:0] reqAddr,
  input wire logic reqWrite,
  input wire logic useSoftDelay,
  output logic reqReady,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic irq,
  output logic convBusy,
  // Converter pins
  input wire logic busyN,
  input wire logic [11:0] adcData,
  output logic conversionStartN,
  output logic readN,
  output logic chipSelectN,
  output logic hostBusStrobeN,
  output logic readWriteN,
  output logic microstateCompleteN,
  output logic addressStrobeN,
  output logic transferAcknowledgeN
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_READ = 5'b00010,
    S_DONE = 5'b00100,
    S_START = 5'b01000,
    S_WAIT = 5'b10000
  } state_t;

  state_t state_q;
  logic [adc_glue_pkg::CNT_W-1:0] cnt_q;
  logic [adc_glue_pkg::CNT_W-1:0] irqCnt_q;
  logic [adc_glue_pkg::CNT_W-1:0] waitCnt_q;
  logic busyPrev_q;
  logic resultReady_q;
  logic [3:0] nibble_q;
  logic [7:0] rspData_q;
  logic rspValid_q;
  logic isLow_q;
  logic strobe_q;
  logic busyRise;
  logic busyFall;

  assign busyRise = busyN && !busyPrev_q;
  assign busyFall = !busyN && busyPrev_q;

  // Previous busy sample, registered for busy edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busyPrev_q <= 1'b1;
    end else begin
      busyPrev_q <= busyN;
    end
  end

  // Conversion start: decoded write only, low for a fixed pulse timed internally by cnt_q
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      strobe_q <= 1'b0;
      isLow_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (reqValid && reqReady) begin
            cnt_q <= '0;
            isLow_q <= (reqAddr == adc_glue_pkg::ADDR_LOW);
            if (reqWrite && reqAddr == adc_glue_pkg::ADDR_START) begin
              state_q <= S_START;
            end else if (!reqWrite && reqAddr != adc_glue_pkg::ADDR_START) begin
              state_q <= S_READ;
              strobe_q <= 1'b1;
            end else begin
              state_q <= S_DONE;
            end
          end
        end
        S_START: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == adc_glue_pkg::CNT_W'(adc_glue_pkg::START_PULSE_CYC - 1)) begin
            state_q <= S_DONE;
          end
        end
        S_READ: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == adc_glue_pkg::CNT_W'(adc_glue_pkg::READ_CYC - 1)) begin
            state_q <= S_WAIT;
            strobe_q <= 1'b0;
          end
        end
        S_WAIT: begin
          state_q <= S_DONE;
        end
        S_DONE: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Reads other than of the high byte wait for a finished conversion, by busy or by soft delay
  always_comb begin
    reqReady = (state_q == S_IDLE) &&
      (reqWrite || reqAddr == adc_glue_pkg::ADDR_HIGH || resultReady_q);
  end

  // Result-ready flag: set by busy end or soft-delay expiry, cleared by start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resultReady_q <= 1'b0;
      waitCnt_q <= '0;
    end else begin
      if (state_q == S_START || busyFall) begin
        waitCnt_q <= adc_glue_pkg::CNT_W'(adc_glue_pkg::CONV_WAIT_CYC);
      end else if (waitCnt_q != '0) begin
        waitCnt_q <= waitCnt_q - 1'b1;
      end
      if (!useSoftDelay && busyRise) begin
        resultReady_q <= 1'b1;
      end else if (useSoftDelay && waitCnt_q == adc_glue_pkg::CNT_W'(1)) begin
        resultReady_q <= 1'b1;
      end else if (state_q == S_START || busyFall) begin
        resultReady_q <= 1'b0;
      end
    end
  end

  // One-shot interrupt on end of conversion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqCnt_q <= '0;
    end else if (busyRise) begin
      irqCnt_q <= adc_glue_pkg::CNT_W'(adc_glue_pkg::IRQ_PULSE_CYC);
    end else if (irqCnt_q != '0) begin
      irqCnt_q <= irqCnt_q - 1'b1;
    end
  end

  // Holding latch and read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nibble_q <= 4'h0;
      rspData_q <= 8'h00;
      rspValid_q <= 1'b0;
    end else begin
      rspValid_q <= 1'b0;
      if (state_q == S_READ && cnt_q == adc_glue_pkg::CNT_W'(adc_glue_pkg::READ_CYC - 1)) begin
        rspValid_q <= 1'b1;
        if (isLow_q) begin
          rspData_q <= adcData[7:0];
          nibble_q <= adcData[11:8];
        end else begin
          rspData_q <= {4'h0, nibble_q};
        end
      end else if (state_q == S_START) begin
        rspValid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    irq = (irqCnt_q != '0);
    convBusy = !busyN;
    rspValid = rspValid_q;
    rspData = rspData_q;
    conversionStartN = !(state_q == S_START);
    hostBusStrobeN = !strobe_q;
    addressStrobeN = !strobe_q;
    readWriteN = 1'b1;
    readN = !(!hostBusStrobeN && readWriteN);
    chipSelectN = readN;
    transferAcknowledgeN = chipSelectN;
    microstateCompleteN = readN || (cnt_q == '0);
  end
endmodule : adc_host_bus_glue

// ===== src/adc_glue_pkg.sv
// Constants for the converter host-side glue logic
package adc_glue_pkg;
  localparam int DATA_W = 12;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 4;
  localparam int CLK_MHZ = 200;
  // One-shot interrupt pulse width
  localparam int IRQ_PULSE_NS = 50;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  // Software-delay wait before reading
  localparam int CONV_WAIT_NS = 15000;
  localparam int CONV_WAIT_CYC = (CONV_WAIT_NS * CLK_MHZ + 999) / 1000;
  // Low width of a generated start pulse
  localparam int START_PULSE_NS = 100;
  localparam int START_PULSE_CYC = (START_PULSE_NS * CLK_MHZ + 999) / 1000;
  // Cycles the read strobe stays low, including one wait state
  localparam int READ_CYC = 4;
  localparam int CNT_W = 16;
  localparam logic [1:0] ADDR_LOW = 2'h0;
  localparam logic [1:0] ADDR_HIGH = 2'h1;
  localparam logic [1:0] ADDR_START = 2'h2;
endpackage : adc_glue_pkg

// ===== test/adc_glue_monitor.sv
// Port checker for the host-side glue
`timescale 1ns/1ps
module adc_glue_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic busyN,
  input wire logic irq,
  input wire logic rspValid,
  input wire logic conversionStartN,
  input wire logic readN,
  input wire logic chipSelectN,
  input wire logic hostBusStrobeN,
  input wire logic addressStrobeN,
  input wire logic readWriteN,
  input wire logic microstateCompleteN,
  input wire logic transferAcknowledgeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence readWin; !readN[*4] ##1 readN; endsequence
  sequence waitSt; microstateCompleteN ##1 !microstateCompleteN[*3]; endsequence
  read_len_a: assert property ($fell(readN) |-> readWin) else $error("rd len");
  wait_state_a: assert property ($fell(readN) |-> waitSt) else $error("wait st");
  strobe_dir_a: assert property ($fell(readN) |->
    !hostBusStrobeN && !addressStrobeN && readWriteN) else $error("strobe");
  ack_decode_a: assert property (readN == chipSelectN
    && readN == transferAcknowledgeN) else $error("ack");
  rsp_time_a: assert property ($fell(readN) |-> ##4 rspValid) else $error("rsp");
  start_width_a: assert property ($fell(conversionStartN) |->
    ##19 !conversionStartN ##1 conversionStartN) else $error("start");
  irq_end_a: assert property ($rose(busyN) |-> ##[1:2] irq) else $error("irq");
  no_busy_read_a: assert property (!busyN |-> readN) else $error("busy rd");
endmodule : adc_glue_monitor
bind adc_host_bus_glue adc_glue_monitor mon (.*);

// ===== test/adc_model.sv
// Converter model: busy while converting, data while read low
`timescale 1ns/1ps
module adc_model (
  input wire logic clk,
  input wire logic conversionStartN,
  input wire logic readN,
  output logic busyN,
  output logic [11:0] adcData
);
  localparam int CONV_CYC = 40;
  logic [11:0] result = 12'hA5C;
  int cnt = 0;
  initial busyN = 1'h1;
  always @(posedge clk) begin
    if (!conversionStartN && busyN) begin
      busyN <= 1'h0;
      cnt <= CONV_CYC;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (!busyN) begin
      busyN <= 1'h1;
      result <= result + 12'h35B;
    end
  end
  assign adcData = readN ? ~result : result;
endmodule : adc_model

// ===== test/tb_adc_host_bus_glue.sv
// Bench: start writes, split reads, refusal, soft delay
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmpCount++; if ((a) !== (e)) begin nMismatch++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module tb_adc_host_bus_glue;
  typedef struct {logic [1:0] a; logic w;} row_t;
  logic clk = 0, rstn = 0, reqValid = 0, reqWrite = 0, useSoftDelay = 0;
  logic [1:0] reqAddr = 2'h0;
  logic reqReady, rspValid, irq, convBusy, busyN, conversionStartN, readN, chipSelectN;
  logic hostBusStrobeN, readWriteN, microstateCompleteN, addressStrobeN, transferAcknowledgeN;
  logic [7:0] rspData, got;
  logic [11:0] adcData, res = 12'hA5C;
  logic [3:0] hi;
  int nMismatch = 0, cmpCount = 0, wt;
  row_t rows[5] = '{'{2'h2, 1'h1}, '{2'h0, 1'h0}, '{2'h1, 1'h0}, '{2'h0, 1'h1}, '{2'h0, 1'h0}};
  always #2.5 clk = ~clk;
  adc_host_bus_glue dut (.*);
  adc_model dev (.*);
  task automatic giveVerdict;
    $display("Compared %0d, mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : giveVerdict
  task automatic op(input logic [1:0] a, input logic w);
    reqAddr <= a;
    reqWrite <= w;
    reqValid <= 1'h1;
    wt = 0;
    @(posedge clk);
    while (reqReady !== 1'h1 && wt < 4000) begin
      @(posedge clk);
      wt++;
    end
    reqValid <= 1'h0;
    if (wt >= 4000) begin
      nMismatch++;
      giveVerdict();
    end
    if (w) repeat (22) @(posedge clk);
    else for (int i = 0; i < 9 && rspValid !== 1'h1; i++) @(posedge clk);
    got = rspData;
  endtask : op
  initial begin
    repeat (6) @(posedge clk);
    `CHK("readN", 1'h1, readN)
    rstn <= 1'h1;
    @(posedge clk);
    foreach (rows[k]) begin
      op(rows[k].a, rows[k].w);
      if (rows[k].w && rows[k].a == adc_glue_pkg::ADDR_START) res = res + 12'h35B;
      if (!rows[k].w) `CHK("data", rows[k].a ? {4'h0, res[11:8]} : res[7:0], got)
      $display("Row %0d done", k);
    end
    hi = res[11:8];
    op(2'h2, 1'h1);
    res = res + 12'h35B;
    reqAddr <= 2'h0;
    reqWrite <= 1'h0;
    @(posedge clk);
    `CHK("refuse", 1'h0, reqReady)
    `CHK("convBusy", 1'h1, convBusy)
    for (wt = 0; wt < 200 && irq !== 1'h1; wt++) @(posedge clk);
    `CHK("irq", 1'h1, irq)
    op(2'h1, 1'h0);
    `CHK("heldNibble", {4'h0, hi}, got)
    op(2'h0, 1'h0);
    `CHK("newLow", res[7:0], got)
    useSoftDelay <= 1'h1;
    op(2'h2, 1'h1);
    res = res + 12'h35B;
    op(2'h0, 1'h0);
    `CHK("softWait", 1'h1, wt > 2900)
    `CHK("softData", res[7:0], got)
    $display("Hand tests done");
    giveVerdict();
  end
endmodule : tb_adc_host_bus_glue
